// >>> hdl/scp_pkg.sv
// Package for the system clock prescaler and PLL control block.
// Assumes one 25 MHz master clock and an AXI4-Lite register bus.
package scp_pkg;
  // Bus geometry.
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 32;
  localparam logic [3:0]  OFF_PRESC   = 4'h0;
  localparam logic [3:0]  OFF_PLL     = 4'h4;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // Prescale register layout and reset values.
  localparam int          UNLOCK_BIT  = 7;
  localparam int          SEL_W       = 4;
  localparam logic [7:0]  UNLOCK_KEY  = 8'h80;
  localparam logic [3:0]  SEL_RST_OFF = 4'h0;
  localparam logic [3:0]  SEL_RST_DIV8 = 4'h3;
  localparam logic [3:0]  SEL_MAX     = 4'h8;
  localparam logic [2:0]  UNLOCK_CYC  = 3'h4;
  // PLL register layout.
  localparam int          PLL_EN_BIT  = 1;
  localparam int          PLL_LK_BIT  = 0;
  localparam int          PDIV_LSB    = 2;
  localparam int          PDIV_W      = 3;
  localparam logic [2:0]  PDIV_BY4    = 3'h3;
  localparam logic [2:0]  PDIV_BY8A   = 3'h5;
  localparam logic [2:0]  PDIV_BY8B   = 3'h6;
  localparam logic [3:0]  PFAC_4      = 4'h4;
  localparam logic [3:0]  PFAC_8      = 4'h8;
  localparam logic [4:0]  PLL_MULT    = 5'h18;
  // Timing.
  localparam int          CLK_HZ      = 25_000_000;
  localparam int          LOCK_MS     = 100;
  localparam int          LOCK_CYC    = LOCK_MS * (CLK_HZ / 1000);
endpackage : scp_pkg

// >>> hdl/scp_top.sv
// System clock prescaler with timed unlock, clock output pin and USB PLL
// control, reached over AXI4-Lite.
// Assumes fuse and source-select levels are static pins from outside the
// aclk domain; divided clocks leave as one-cycle enable pulses.
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - Clock-drive fuse puts system clock on pin.
// - Pin keeps clocking in reset, overrides GPIO.
// - Pin carries the divided system clock.
// - One factor divides all four clock domains.
// - Divider switches without glitches.
// - No period shorter than old or new.
// - New rate within T1+T2 to T1+2T2; divider here switches at the next tick, within T1.
// - Unlock sets only on exact key write.
// - Select written only inside unlock window.
// - Unlock clears after four cycles or select write.
// - Rewriting unlock neither restarts nor clears.
// - Select resets to 0000, or 0011 with fuse.
// - Any select value accepted regardless of fuse.
// - Select code n divides by two to n.
// - PLL multiplies 2 MHz reference by 24.
// - Input divider codes give four or eight.
// - PLL enable bit starts the PLL.
// - Lock flag sets about 100 ms after enable.
// - Lock clears when enable and divider cleared.
// - Parts ship with divide-by-eight fuse programmed.
module scp_top #(
  parameter int LOCK_CYCLES = scp_pkg::LOCK_CYC
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [scp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [scp_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [scp_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [scp_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       divide_by_eight_fuse,
  input  wire logic                       clock_drive_fuse,
  input  wire logic                       rc_source_selected,
  output logic                            core_clock_en,
  output logic                            io_domain_clock_en,
  output logic                            converter_clock_en,
  output logic                            program_memory_clock_en,
  output logic                            sysclk_out_pin_o,
  output logic                            sysclk_out_pin_oe,
  output logic                            pll_run,
  output logic [3:0]                      pll_ref_factor,
  output logic [4:0]                      pll_mult_factor,
  output logic                            pll_locked_flag
);
  import scp_pkg::*;

  // Every check in this module runs on the master clock, off in reset.
  default clocking scp_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  localparam int LCW = $clog2(LOCK_CYCLES + 1);

  // Refuse a lock time the counter cannot represent.
  if (LOCK_CYCLES < 1) begin : g_chk
    $error("LOCK_CYCLES must be at least one");
  end

  // Division limit for a select code; reserved codes act as 256.
  function automatic logic [7:0] div_limit(input logic [3:0] code);
    logic [8:0] f;
    f = 9'h001 << ((code > SEL_MAX) ? SEL_MAX : code);
    return 8'(f - 9'h001);
  endfunction : div_limit

  // PLL reference division factor, zero for reserved codes.
  function automatic logic [3:0] pdiv_factor(input logic [2:0] code);
    logic [3:0] f;
    f = 4'h0;
    if (code == PDIV_BY4) begin
      f = PFAC_4;
    end else if (code == PDIV_BY8A || code == PDIV_BY8B) begin
      f = PFAC_8;
    end
    return f;
  endfunction : pdiv_factor

  // Two-flop synchronisers for the static pins.
  logic [2:0] pin_m;
  logic [2:0] pin_s;
  always_ff @(posedge aclk) begin
    pin_m <= {rc_source_selected, clock_drive_fuse, divide_by_eight_fuse};
    pin_s <= pin_m;
  end

  logic       fuse_div8;
  logic       fuse_drive;
  logic       rc_sel;
  assign fuse_div8  = pin_s[0];
  assign fuse_drive = pin_s[1];
  assign rc_sel     = pin_s[2];

  // Register state.
  logic [3:0] sel_r;
  logic       unlock;
  logic [2:0] tmr;
  logic       pend;
  logic [3:0] div_sel;
  logic [7:0] cnt;
  logic       tick;
  logic       clk_tgl;
  logic       rst_q;
  logic       pll_enable;
  logic [2:0] pll_input_divider;
  logic [LCW-1:0] lock_cnt;

  // AXI write channel holding registers.
  logic [ADDR_W-1:0] aw_addr;
  logic              aw_full;
  logic [7:0]        w_data;
  logic              w_lane0;
  logic              w_full;
  logic              wr_go;
  logic              wr_presc;
  logic              wr_pll;
  logic              wr_bad;

  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign wr_go         = aw_full && w_full && !s_axi_bvalid;

  // Address decode of the held write.
  always_comb begin
    wr_presc = 1'b0;
    wr_pll   = 1'b0;
    wr_bad   = 1'b0;
    if (aw_addr == OFF_PRESC) begin
      wr_presc = wr_go && w_lane0;
    end else if (aw_addr == OFF_PLL) begin
      wr_pll = wr_go && w_lane0;
    end else begin
      wr_bad = 1'b1;
    end
  end

  // Address and data are taken in either order and held until used.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full  <= 1'b1;
        w_data  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_full <= 1'b0;
      end
    end
  end

  // Write response, one cycle after both halves are held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_bad ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Unlock bit and its four-cycle timeout counted on core clock ticks.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock <= 1'b0;
      tmr    <= 3'h0;
    end else if (wr_presc && !unlock && w_data == UNLOCK_KEY) begin
      unlock <= 1'b1;
      tmr    <= 3'h0;
    end else if (wr_presc && unlock && !w_data[UNLOCK_BIT]) begin
      unlock <= 1'b0;
    end else if (unlock && tick) begin
      tmr <= tmr + 3'h1;
      if (tmr + 3'h1 == UNLOCK_CYC) begin
        unlock <= 1'b0;
      end
    end
  end

  // Select bits: fuse value at reset, written only while unlocked.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_r <= fuse_div8 ? SEL_RST_DIV8 : SEL_RST_OFF;
    end else if (wr_presc && unlock && !w_data[UNLOCK_BIT]) begin
      sel_r <= w_data[SEL_W-1:0];
    end
  end

  // A new select waits for the end of the running period, so the
  // current period is never cut short and the next one is whole.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend <= 1'b1;
    end else if (wr_presc && unlock && !w_data[UNLOCK_BIT]) begin
      pend <= 1'b1;
    end else if (tick) begin
      pend <= 1'b0;
    end
  end

  // Counting divider on the master clock. It runs at factor one through
  // reset after seeding itself on the first reset cycle; the reset select
  // loads at the first tick after release, as pend is set in reset, so an
  // unsettled fuse sample never reaches the divider.
  always_ff @(posedge aclk) begin
    rst_q <= aresetn;
    if (!aresetn && !rst_q) begin
      if (tick) begin
        cnt     <= 8'h00;
        clk_tgl <= !clk_tgl;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end else if (!aresetn) begin
      cnt     <= 8'h00;
      div_sel <= SEL_RST_OFF;
      clk_tgl <= 1'b0;
    end else if (tick) begin
      cnt     <= 8'h00;
      clk_tgl <= !clk_tgl;
      if (pend) begin
        div_sel <= sel_r;
      end
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  assign tick = (cnt >= div_limit(div_sel));

  // One enable serves every synchronous domain.
  assign core_clock_en           = tick;
  assign io_domain_clock_en      = tick;
  assign converter_clock_en      = tick;
  assign program_memory_clock_en = tick;

  // Divided clock on the pin, driven even in reset when the fuse is set.
  assign sysclk_out_pin_o  = clk_tgl && fuse_drive;
  assign sysclk_out_pin_oe = fuse_drive;

  // PLL control bits; reserved bits and the lock flag ignore writes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_enable        <= 1'b0;
      pll_input_divider <= 3'h0;
    end else if (wr_pll) begin
      pll_enable        <= w_data[PLL_EN_BIT];
      pll_input_divider <= w_data[PDIV_LSB +: PDIV_W];
    end
  end

  // The PLL runs only from the crystal or external clock.
  assign pll_run         = pll_enable && !rc_sel;
  assign pll_ref_factor  = pdiv_factor(pll_input_divider);
  assign pll_mult_factor = PLL_MULT;

  // Lock timer; the flag stays until enable and divider are both clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_cnt        <= '0;
      pll_locked_flag <= 1'b0;
    end else if (!pll_enable && pll_input_divider == 3'h0) begin
      lock_cnt        <= '0;
      pll_locked_flag <= 1'b0;
    end else if (pll_run && !pll_locked_flag) begin
      if (lock_cnt == LCW'(LOCK_CYCLES - 1)) begin
        pll_locked_flag <= 1'b1;
      end
      lock_cnt <= lock_cnt + LCW'(1);
    end
  end

  // Read channel, data one cycle after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= '0;
      if (s_axi_araddr == OFF_PRESC) begin
        s_axi_rdata[7:0] <= {unlock, 3'h0, sel_r};
      end else if (s_axi_araddr == OFF_PLL) begin
        s_axi_rdata[7:0] <= {3'h0, pll_input_divider, pll_enable,
                             pll_locked_flag};
      end else begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on the unlock sequence, divider and PLL status.
  chk_unlock_set: assert property (
    wr_presc && !unlock && w_data == UNLOCK_KEY |=> unlock)
    else $error("unlock not set by key write");
  chk_unlock_other: assert property (
    wr_presc && !unlock && w_data != UNLOCK_KEY |=> !unlock)
    else $error("unlock set by a non-key write");
  chk_sel_guard: assert property (
    wr_presc && !unlock |=> $stable(sel_r))
    else $error("select changed while locked");
  chk_sel_load: assert property (
    wr_presc && unlock && !w_data[UNLOCK_BIT]
    |=> sel_r == $past(w_data[3:0]) && !unlock)
    else $error("select write inside window failed");
  chk_unlock_tmo: assert property (
    unlock && tick && tmr == 3'h3 |=> !unlock)
    else $error("unlock outlived four cycles");
  chk_no_restart: assert property (
    wr_presc && unlock && w_data == UNLOCK_KEY && !(tick && tmr == 3'h3)
    |=> unlock && tmr >= $past(tmr))
    else $error("rewrite restarted or cleared unlock");
  chk_switch_edge: assert property (
    tick && pend |=> div_sel == $past(sel_r))
    else $error("divider did not switch at boundary");
  chk_no_runt: assert property (
    tick ##1 div_sel != 4'h0 |-> !tick)
    else $error("short divided period");
  chk_sel_reset: assert property (
    $rose(aresetn) |-> sel_r == (fuse_div8 ? SEL_RST_DIV8 : SEL_RST_OFF))
    else $error("select reset value wrong");
  chk_lock_clear: assert property (
    !pll_enable && pll_input_divider == 3'h0 |=> !pll_locked_flag)
    else $error("lock flag survived clear");
  chk_pll_rsvd: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_PLL
    |=> s_axi_rdata[31:5] == '0)
    else $error("reserved read bits not zero");

  cov_unlock_use: cover property (@(posedge aclk) disable iff (!aresetn)
    unlock ##[1:8] (wr_presc && unlock && !w_data[UNLOCK_BIT]));
  cov_timeout: cover property (@(posedge aclk) disable iff (!aresetn)
    unlock ##1 !unlock && !$past(wr_presc));
  cov_switch: cover property (@(posedge aclk) disable iff (!aresetn)
    tick && pend && div_sel != sel_r);
  cov_lock: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(pll_locked_flag));
endmodule : scp_top

// >>> sim/test_scp_top.sv
// Self-checking testbench for the clock prescaler and PLL control block.
// Assumes scp_pkg and scp_top are compiled first; LOCK_CYCLES is shortened.
`timescale 1ns/1ps
module test_scp_top;
  import scp_pkg::*;
  localparam int LOCK_SIM = 20;
  logic              aclk, aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic              s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
  logic              s_axi_awready, s_axi_wready, s_axi_arready;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_bvalid, s_axi_rvalid;
  logic              div8_fuse, drive_fuse, rc_sel;
  logic              core_en, io_en, conv_en, prog_en, pin_o, pin_oe;
  logic              pll_run;
  logic [3:0]        pll_ref_factor;
  logic [4:0]        pll_mult_factor;
  logic              pll_locked_flag;
  int                n_mismatch, tests_run;

  // Device under test; response ready lines are held high throughout.
  scp_top #(.LOCK_CYCLES(LOCK_SIM)) scp_top_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(1'b1), .divide_by_eight_fuse(div8_fuse),
    .clock_drive_fuse(drive_fuse), .rc_source_selected(rc_sel),
    .core_clock_en(core_en), .io_domain_clock_en(io_en),
    .converter_clock_en(conv_en), .program_memory_clock_en(prog_en),
    .sysclk_out_pin_o(pin_o), .sysclk_out_pin_oe(pin_oe),
    .pll_run(pll_run), .pll_ref_factor(pll_ref_factor),
    .pll_mult_factor(pll_mult_factor), .pll_locked_flag(pll_locked_flag));

  // Master clock of 40 ns period.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task finish_test;
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One write; address and data are held until each is taken.
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    bit aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, er);
  endtask : wr

  // One read, compared with the expected data and response.
  task automatic rd(input logic [3:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask : rd

  // Two-write change sequence; software keeps it uninterrupted.
  task automatic set_sel(input logic [3:0] c);
    wr(OFF_PRESC, UNLOCK_KEY, RESP_OKAY);
    wr(OFF_PRESC, {4'h0, c}, RESP_OKAY);
  endtask : set_sel

  // Cycles between two enable pulses; all four domains must agree.
  task automatic period(output int p);
    p = 0;
    do @(posedge aclk); while (core_en !== 1'b1);
    do begin
      @(posedge aclk);
      p++;
    end while (core_en !== 1'b1);
    chk({io_en, conv_en, prog_en}, 3'b111);
  endtask : period

  // Counts changes of the clock pin over n cycles.
  task automatic toggles(input int n, output int t);
    logic prev;
    t = 0;
    prev = pin_o;
    repeat (n) begin
      @(posedge aclk);
      if (pin_o !== prev) t++;
      prev = pin_o;
    end
  endtask : toggles

  // Reset values, unmapped access and pin enable after start-up.
  task automatic t_reset;
    rd(OFF_PRESC, 32'h03, RESP_OKAY);
    rd(OFF_PLL, 32'h00, RESP_OKAY);
    rd(4'h8, 32'h00, RESP_SLVERR);
    wr(4'h8, 8'hFF, RESP_SLVERR);
    chk(pin_oe, 1'b1);
  endtask : t_reset

  // Select codes 0 to 8 each divide by two to their power, with readback.
  task automatic t_select;
    int p;
    for (int c = 0; c <= 8; c++) begin
      set_sel(c[3:0]);
      rd(OFF_PRESC, c, RESP_OKAY);
      period(p);
      chk(p, 1 << c);
    end
  endtask : t_select

  // Bad key, late select write and rewriting the key in the window.
  task automatic t_unlock;
    int p;
    set_sel(4'h0);
    wr(OFF_PRESC, 8'h81, RESP_OKAY);
    rd(OFF_PRESC, 32'h00, RESP_OKAY);
    wr(OFF_PRESC, 8'h05, RESP_OKAY);
    rd(OFF_PRESC, 32'h00, RESP_OKAY);
    set_sel(4'h4);
    period(p);
    chk(p, 16);
    wr(OFF_PRESC, UNLOCK_KEY, RESP_OKAY);
    rd(OFF_PRESC, 32'h84, RESP_OKAY);
    repeat (28) @(posedge aclk);
    wr(OFF_PRESC, UNLOCK_KEY, RESP_OKAY);
    rd(OFF_PRESC, 32'h84, RESP_OKAY);
    repeat (30) @(posedge aclk);
    rd(OFF_PRESC, 32'h04, RESP_OKAY);
    wr(OFF_PRESC, 8'h01, RESP_OKAY);
    rd(OFF_PRESC, 32'h04, RESP_OKAY);
  endtask : t_unlock

  // Pin carries the divided clock, also in reset, until the fuse drops.
  task automatic t_pin;
    int t;
    set_sel(4'h1);
    period(t);
    chk(t, 2);
    toggles(32, t);
    chk(t, 16);
    div8_fuse <= 1'b0;
    aresetn <= 1'b0;
    toggles(8, t);
    chk(t != 0, 1'b1);
    chk(pin_oe, 1'b1);
    aresetn <= 1'b1;
    rd(OFF_PRESC, 32'h00, RESP_OKAY);
    drive_fuse <= 1'b0;
    repeat (4) @(posedge aclk);
    chk({pin_oe, pin_o}, 2'b00);
  endtask : t_pin

  // Reserved bits, divider codes, lock timing and lock clearing.
  task automatic t_pll;
    logic [2:0] codes [3];
    logic [3:0] facs [3];
    codes = '{PDIV_BY4, PDIV_BY8A, PDIV_BY8B};
    facs = '{PFAC_4, PFAC_8, PFAC_8};
    wr(OFF_PLL, 8'hFF, RESP_OKAY);
    rd(OFF_PLL, 32'h1E, RESP_OKAY);
    chk({pll_run, pll_ref_factor}, 5'h10);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_PLL, {3'h0, codes[i], 2'b10}, RESP_OKAY);
      chk(pll_ref_factor, facs[i]);
      chk(pll_mult_factor, PLL_MULT);
    end
    wr(OFF_PLL, 8'h00, RESP_OKAY);
    wr(OFF_PLL, 8'h0E, RESP_OKAY);
    repeat (10) @(posedge aclk);
    chk(pll_locked_flag, 1'b0);
    repeat (20) @(posedge aclk);
    rd(OFF_PLL, 32'h0F, RESP_OKAY);
    wr(OFF_PLL, 8'h02, RESP_OKAY);
    chk(pll_locked_flag, 1'b1);
    s_axi_wstrb <= 4'h0;
    wr(OFF_PLL, 8'h00, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    chk(pll_locked_flag, 1'b1);
    wr(OFF_PLL, 8'h00, RESP_OKAY);
    rd(OFF_PLL, 32'h00, RESP_OKAY);
    rc_sel <= 1'b1;
    wr(OFF_PLL, 8'h0E, RESP_OKAY);
    chk(pll_run, 1'b0);
    rc_sel <= 1'b0;
  endtask : t_pll

  // Main sequence.
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    div8_fuse = 1'b1;
    drive_fuse = 1'b1;
    rc_sel = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_select();
    t_unlock();
    t_pll();
    t_pin();
    finish_test();
  end

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    finish_test();
  end
endmodule : test_scp_top
